// file: lookup_engine_control_pkg.sv
// constants and types for the lookup engine control registers
package lookup_engine_control_pkg;
	localparam int          ADDR_W          = 16;
	localparam int          DATA_W          = 8;
	localparam int          NUM_PORTS       = 3;
	localparam int          PORT_IDX_W      = 2;
	localparam int          MAC_W           = 48;
	// host port sits at the highest index
	localparam int          HOST_PORT       = 2;

	localparam logic [15:0] ADDR_CTRL_1     = 16'h0311;
	localparam logic [15:0] ADDR_CTRL_2     = 16'h0312;

	localparam logic [7:0]  CTRL_1_RESET    = 8'h0C;
	localparam logic [7:0]  CTRL_2_RESET    = 8'h00;
	localparam logic [7:0]  READ_IDLE       = 8'h00;

	// first lookup control register fields
	localparam int          B_LEARN_DIS     = 7;
	localparam int          B_SELF_FILT     = 6;
	localparam int          B_FLUSH_ALL     = 5;
	localparam int          B_FLUSH_MSTP    = 4;
	localparam int          B_MC_SA_FWD     = 3;
	localparam int          B_AGING_EN      = 2;
	localparam int          B_FAST_AGING    = 1;
	localparam int          B_LINKDN_FLUSH  = 0;

	// second lookup control register fields
	localparam int          B_DT_MC_TRAP    = 6;
	localparam int          B_DYN_EGR_FILT  = 5;
	localparam int          B_STA_EGR_FILT  = 4;
	localparam int          F_FLUSH_OPT_HI  = 3;
	localparam int          F_FLUSH_OPT_LO  = 2;
	localparam int          F_MACA_PRIO_HI  = 1;
	localparam int          F_MACA_PRIO_LO  = 0;

	// flush option codes
	localparam logic [1:0]  FLUSH_OPT_NONE  = 2'h0;
	localparam logic [1:0]  FLUSH_OPT_DYN   = 2'h1;
	localparam logic [1:0]  FLUSH_OPT_STA   = 2'h2;
	localparam logic [1:0]  FLUSH_OPT_BOTH  = 2'h3;

	// first octet least significant bit marks a group address
	localparam int          SA_GROUP_BIT    = 40;

	typedef enum logic [0:0] {
		FL_IDLE,
		FL_RUN
	} flush_state_t;

	typedef enum logic [1:0] {
		KIND_ALL,
		KIND_MSTP,
		KIND_PORT
	} flush_kind_t;
endpackage

// file: lookup_engine_control.sv
// lookup engine control registers and the decisions they steer
// Summary of operation
// RQ1 - control one bit seven set stops unicast source address learning
// RQ2 - global self filter plus port enable drops frames from our own MAC
// RQ3 - writing one to bit five starts a whole table flush, self clearing
// RQ4 - writing one to bit four flushes MSTP matched entries, self clearing
// RQ5 - bit three set forwards multicast source frames, clear drops them
// RQ6 - bit two enables aging, default one
// RQ7 - bit one selects fast aging, default normal
// RQ8 - bit zero flushes entries of a port whose link goes down
// RQ9 - double tag mode with trap bit sends reserved multicast to host only
// RQ10 - dynamic hit with bit five ANDs lookup map with VLAN map
// RQ11 - static hit with bit four ANDs lookup map with VLAN map
// RQ12 - software should enable egress filtering with VLANs; both reset zero
// RQ13 - flush option picks none, dynamic, static or both entry types
// RQ14 - trigger bit reads one while flushing, zero after the walk ends
`timescale 1ns/10ps
module lookup_engine_control (
	input  wire logic                                         i_clock,
	input  wire logic                                         i_arst_n,
	input  wire logic [lookup_engine_control_pkg::ADDR_W-1:0] i_addr,
	input  wire logic [lookup_engine_control_pkg::DATA_W-1:0] i_wdata,
	input  wire logic                                         i_wr,
	input  wire logic                                         i_rd,
	output logic      [lookup_engine_control_pkg::DATA_W-1:0] o_rdata,
	input  wire logic [lookup_engine_control_pkg::MAC_W-1:0]  i_switch_mac,
	input  wire logic [lookup_engine_control_pkg::NUM_PORTS-1:0] i_port_self_filt_en,
	input  wire logic                                         i_sa_valid,
	input  wire logic [lookup_engine_control_pkg::PORT_IDX_W-1:0] i_sa_port,
	input  wire logic [lookup_engine_control_pkg::MAC_W-1:0]  i_sa,
	output logic                                              o_sa_result_valid,
	output logic                                              o_sa_drop_self,
	output logic                                              o_sa_drop_mcast,
	input  wire logic                                         i_lookup_valid,
	input  wire logic                                         i_lookup_hit,
	input  wire logic                                         i_lookup_static,
	input  wire logic                                         i_lookup_reserved_mc,
	input  wire logic                                         i_double_tag_mode,
	input  wire logic [lookup_engine_control_pkg::NUM_PORTS-1:0] i_lookup_map,
	input  wire logic [lookup_engine_control_pkg::NUM_PORTS-1:0] i_vlan_map,
	output logic                                              o_fwd_valid,
	output logic      [lookup_engine_control_pkg::NUM_PORTS-1:0] o_fwd_map,
	input  wire logic [lookup_engine_control_pkg::NUM_PORTS-1:0] i_link_up,
	input  wire logic                                         i_flush_done,
	output logic                                              o_flush_start,
	output lookup_engine_control_pkg::flush_kind_t            o_flush_kind,
	output logic      [lookup_engine_control_pkg::NUM_PORTS-1:0] o_flush_port_mask,
	output logic                                              o_flush_dynamic,
	output logic                                              o_flush_static,
	output logic                                              o_learn_disable,
	output logic                                              o_aging_enable,
	output logic                                              o_fast_aging,
	output logic      [1:0]                                   o_maca_prio
);
	import lookup_engine_control_pkg::*;

	logic [DATA_W-1:0]    ctrl_1_ff;
	logic [DATA_W-1:0]    ctrl_2_ff;
	logic                 flush_all_ff;
	logic                 flush_mstp_ff;
	logic [NUM_PORTS-1:0] ld_pend_ff;
	logic [NUM_PORTS-1:0] link_up_q_ff;
	logic [DATA_W-1:0]    rdata_ff;
	flush_state_t         state_ff;
	flush_kind_t          kind_ff;
	logic [NUM_PORTS-1:0] port_mask_ff;
	logic                 start_ff;
	logic                 opt_dyn_ff;
	logic                 opt_sta_ff;
	logic                 sa_valid_ff;
	logic                 drop_self_ff;
	logic                 drop_mcast_ff;
	logic                 fwd_valid_ff;
	logic [NUM_PORTS-1:0] fwd_map_ff;

	logic                 wr_1;
	logic                 wr_2;
	logic [1:0]           flush_opt;
	logic                 run_done;
	logic                 clr_all;
	logic                 clr_mstp;
	logic [NUM_PORTS-1:0] clr_ld;
	logic [NUM_PORTS-1:0] link_fall;
	logic                 pick_all;
	logic                 pick_mstp;
	logic                 pick_port;
	logic [NUM_PORTS-1:0] nxt_port_mask;
	logic                 self_port_en;
	logic                 egr_filt;
	logic [NUM_PORTS-1:0] nxt_fwd_map;

	assign wr_1      = i_wr && (i_addr == ADDR_CTRL_1);
	assign wr_2      = i_wr && (i_addr == ADDR_CTRL_2);
	assign flush_opt = ctrl_2_ff[F_FLUSH_OPT_HI:F_FLUSH_OPT_LO];
	assign link_fall = link_up_q_ff & ~i_link_up;

	// plain control bits; the flush triggers live in their own flops
	always_ff @(posedge i_clock or negedge i_arst_n) begin
		if (!i_arst_n) begin
			ctrl_1_ff <= CTRL_1_RESET;
		end else if (wr_1) begin
			ctrl_1_ff <= i_wdata;
		end
	end

	always_ff @(posedge i_clock or negedge i_arst_n) begin
		if (!i_arst_n) begin
			ctrl_2_ff <= CTRL_2_RESET; // [RQ12]
		end else if (wr_2) begin
			ctrl_2_ff <= i_wdata;
		end
	end

	// one flush at a time; whole table first, then MSTP, then link down
	assign pick_all  = flush_all_ff;
	assign pick_mstp = !flush_all_ff && flush_mstp_ff;
	assign pick_port = !flush_all_ff && !flush_mstp_ff && (ld_pend_ff != '0);

	always_comb begin
		nxt_port_mask = '0;
		for (int p = NUM_PORTS - 1; p >= 0; p--) begin
			if (ld_pend_ff[p]) begin
				nxt_port_mask = '0;
				nxt_port_mask[p] = 1'b1;
			end
		end
	end

	// option none removes nothing, so the request finishes without a walk
	assign run_done = (state_ff == FL_RUN) && i_flush_done;

	always_comb begin
		clr_all  = 1'b0;
		clr_mstp = 1'b0;
		clr_ld   = '0;
		if (state_ff == FL_IDLE && flush_opt == FLUSH_OPT_NONE) begin
			clr_all  = pick_all; // [RQ13]
			clr_mstp = pick_mstp;
			clr_ld   = pick_port ? nxt_port_mask : '0;
		end else if (run_done) begin
			clr_all  = (kind_ff == KIND_ALL);
			clr_mstp = (kind_ff == KIND_MSTP);
			clr_ld   = (kind_ff == KIND_PORT) ? port_mask_ff : '0;
		end
	end

	// a write of one in the cycle of completion wins and starts again
	always_ff @(posedge i_clock or negedge i_arst_n) begin
		if (!i_arst_n) begin
			flush_all_ff <= 1'b0;
		end else if (wr_1 && i_wdata[B_FLUSH_ALL]) begin
			flush_all_ff <= 1'b1; // [RQ3]
		end else if (clr_all) begin
			flush_all_ff <= 1'b0; // [RQ14]
		end
	end

	always_ff @(posedge i_clock or negedge i_arst_n) begin
		if (!i_arst_n) begin
			flush_mstp_ff <= 1'b0;
		end else if (wr_1 && i_wdata[B_FLUSH_MSTP]) begin
			flush_mstp_ff <= 1'b1; // [RQ4]
		end else if (clr_mstp) begin
			flush_mstp_ff <= 1'b0; // [RQ14]
		end
	end

	// link state comes from logic on this clock, so no synchroniser
	always_ff @(posedge i_clock or negedge i_arst_n) begin
		if (!i_arst_n) begin
			link_up_q_ff <= '0;
		end else begin
			link_up_q_ff <= i_link_up;
		end
	end

	// pending port flushes; a fresh link drop beats the clear
	always_ff @(posedge i_clock or negedge i_arst_n) begin
		if (!i_arst_n) begin
			ld_pend_ff <= '0;
		end else begin
			ld_pend_ff <= (ld_pend_ff & ~clr_ld)
				| (link_fall & {NUM_PORTS{ctrl_1_ff[B_LINKDN_FLUSH]}}); // [RQ8]
		end
	end

	always_ff @(posedge i_clock or negedge i_arst_n) begin
		if (!i_arst_n) begin
			state_ff     <= FL_IDLE;
			kind_ff      <= KIND_ALL;
			port_mask_ff <= '0;
			start_ff     <= 1'b0;
			opt_dyn_ff   <= 1'b0;
			opt_sta_ff   <= 1'b0;
		end else begin
			start_ff <= 1'b0;
			unique case (state_ff)
				FL_IDLE: begin
					if ((pick_all || pick_mstp || pick_port)
						&& flush_opt != FLUSH_OPT_NONE) begin
						state_ff   <= FL_RUN;
						start_ff   <= 1'b1;
						// option is latched so a change mid walk cannot split it
						opt_dyn_ff <= (flush_opt == FLUSH_OPT_DYN)
							|| (flush_opt == FLUSH_OPT_BOTH); // [RQ13]
						opt_sta_ff <= (flush_opt == FLUSH_OPT_STA)
							|| (flush_opt == FLUSH_OPT_BOTH);
						if (pick_all) begin
							kind_ff      <= KIND_ALL;
							port_mask_ff <= {NUM_PORTS{1'b1}};
						end else if (pick_mstp) begin
							kind_ff      <= KIND_MSTP;
							port_mask_ff <= {NUM_PORTS{1'b1}};
						end else begin
							kind_ff      <= KIND_PORT;
							port_mask_ff <= nxt_port_mask;
						end
					end
				end
				FL_RUN: begin
					if (i_flush_done) begin
						state_ff   <= FL_IDLE;
						opt_dyn_ff <= 1'b0;
						opt_sta_ff <= 1'b0;
					end
				end
			endcase
		end
	end

	// source address checks, one cycle after the address is presented
	always_comb begin
		self_port_en = 1'b0;
		for (int p = 0; p < NUM_PORTS; p++) begin
			if (i_sa_port == PORT_IDX_W'(p)) begin
				self_port_en = i_port_self_filt_en[p];
			end
		end
	end

	always_ff @(posedge i_clock or negedge i_arst_n) begin
		if (!i_arst_n) begin
			sa_valid_ff   <= 1'b0;
			drop_self_ff  <= 1'b0;
			drop_mcast_ff <= 1'b0;
		end else begin
			sa_valid_ff   <= i_sa_valid;
			drop_self_ff  <= i_sa_valid && ctrl_1_ff[B_SELF_FILT] && self_port_en
				&& (i_sa == i_switch_mac); // [RQ2]
			drop_mcast_ff <= i_sa_valid && !ctrl_1_ff[B_MC_SA_FWD]
				&& i_sa[SA_GROUP_BIT]; // [RQ5]
		end
	end

	// forwarding map: trap first, then egress VLAN filtering
	assign egr_filt = i_lookup_static ? ctrl_2_ff[B_STA_EGR_FILT] // [RQ11]
		: ctrl_2_ff[B_DYN_EGR_FILT]; // [RQ10]

	always_comb begin
		nxt_fwd_map = i_lookup_map;
		if (i_double_tag_mode && i_lookup_reserved_mc && ctrl_2_ff[B_DT_MC_TRAP]) begin
			nxt_fwd_map = '0;
			nxt_fwd_map[HOST_PORT] = 1'b1; // [RQ9]
		end else if (i_lookup_hit && egr_filt) begin
			nxt_fwd_map = i_lookup_map & i_vlan_map; // [RQ10] [RQ11]
		end
	end

	always_ff @(posedge i_clock or negedge i_arst_n) begin
		if (!i_arst_n) begin
			fwd_valid_ff <= 1'b0;
			fwd_map_ff   <= '0;
		end else begin
			fwd_valid_ff <= i_lookup_valid;
			fwd_map_ff   <= i_lookup_valid ? nxt_fwd_map : '0;
		end
	end

	// read data stands only in the cycle after the strobe
	always_ff @(posedge i_clock or negedge i_arst_n) begin
		if (!i_arst_n) begin
			rdata_ff <= READ_IDLE;
		end else if (i_rd && i_addr == ADDR_CTRL_1) begin
			rdata_ff <= ctrl_1_ff;
			rdata_ff[B_FLUSH_ALL]  <= flush_all_ff; // [RQ14]
			rdata_ff[B_FLUSH_MSTP] <= flush_mstp_ff;
		end else if (i_rd && i_addr == ADDR_CTRL_2) begin
			rdata_ff <= ctrl_2_ff;
		end else begin
			rdata_ff <= READ_IDLE;
		end
	end

	assign o_rdata           = rdata_ff;
	assign o_sa_result_valid = sa_valid_ff;
	assign o_sa_drop_self    = drop_self_ff;
	assign o_sa_drop_mcast   = drop_mcast_ff;
	assign o_fwd_valid       = fwd_valid_ff;
	assign o_fwd_map         = fwd_map_ff;
	assign o_flush_start     = start_ff;
	assign o_flush_kind      = kind_ff;
	assign o_flush_port_mask = port_mask_ff;
	assign o_flush_dynamic   = opt_dyn_ff;
	assign o_flush_static    = opt_sta_ff;
	assign o_learn_disable   = ctrl_1_ff[B_LEARN_DIS]; // [RQ1]
	assign o_aging_enable    = ctrl_1_ff[B_AGING_EN]; // [RQ6]
	assign o_fast_aging      = ctrl_1_ff[B_FAST_AGING]; // [RQ7]
	assign o_maca_prio       = ctrl_2_ff[F_MACA_PRIO_HI:F_MACA_PRIO_LO];
endmodule

// file: lec_checker_properties.sv
// port assertions for the lookup engine control registers
`timescale 1ns/10ps
module lec_checker (
	input wire logic        i_clock,
	input wire logic        i_arst_n,
	input wire logic [15:0] i_addr,
	input wire logic [7:0]  i_wdata,
	input wire logic        i_wr,
	input wire logic        i_sa_valid,
	input wire logic [47:0] i_sa,
	input wire logic        o_sa_result_valid,
	input wire logic        o_sa_drop_mcast,
	input wire logic        i_lookup_valid,
	input wire logic        i_lookup_hit,
	input wire logic        i_lookup_static,
	input wire logic        i_lookup_reserved_mc,
	input wire logic        i_double_tag_mode,
	input wire logic [2:0]  i_lookup_map,
	input wire logic [2:0]  i_vlan_map,
	input wire logic        o_fwd_valid,
	input wire logic [2:0]  o_fwd_map,
	input wire logic        i_flush_done,
	input wire logic        o_flush_start,
	input wire lookup_engine_control_pkg::flush_kind_t o_flush_kind,
	input wire logic [2:0]  o_flush_port_mask,
	input wire logic        o_flush_dynamic,
	input wire logic        o_flush_static,
	input wire logic        o_learn_disable,
	input wire logic        o_aging_enable,
	input wire logic        o_fast_aging
);
	import lookup_engine_control_pkg::*;
	logic [2:0] ctl2_ff;
	logic       mcf_ff;
	logic [2:0] exp_map;
	// shadow of the steering bits, the design hides them behind the bus
	always_ff @(posedge i_clock or negedge i_arst_n) begin
		if (!i_arst_n) begin
			ctl2_ff <= 3'h0;
		end else if (i_wr && i_addr == ADDR_CTRL_2) begin
			ctl2_ff <= i_wdata[6:4];
		end
	end
	always_ff @(posedge i_clock or negedge i_arst_n) begin
		if (!i_arst_n) begin
			mcf_ff <= 1'b1;
		end else if (i_wr && i_addr == ADDR_CTRL_1) begin
			mcf_ff <= i_wdata[B_MC_SA_FWD];
		end
	end
	assign exp_map = (i_double_tag_mode && i_lookup_reserved_mc && ctl2_ff[2]) ? 3'h4 :
		(i_lookup_hit && (i_lookup_static ? ctl2_ff[0] : ctl2_ff[1])) ?
		(i_lookup_map & i_vlan_map) : i_lookup_map;
	default clocking cb @(posedge i_clock); endclocking
	default disable iff (!i_arst_n);
	chk_learn_bit: assert property (i_wr && i_addr == ADDR_CTRL_1 |=>
		o_learn_disable == $past(i_wdata[B_LEARN_DIS])) else $error("learn disable wrong");
	chk_aging_bit: assert property (i_wr && i_addr == ADDR_CTRL_1 |=>
		o_aging_enable == $past(i_wdata[B_AGING_EN])) else $error("aging enable wrong");
	chk_fast_aging: assert property (i_wr && i_addr == ADDR_CTRL_1 |=>
		o_fast_aging == $past(i_wdata[B_FAST_AGING])) else $error("fast aging wrong");
	chk_fwd_map: assert property (i_lookup_valid |=> o_fwd_valid &&
		o_fwd_map == $past(exp_map)) else $error("forward map wrong");
	chk_fwd_idle: assert property (!i_lookup_valid |=> !o_fwd_valid
		&& o_fwd_map == 3'h0) else $error("forward result without lookup");
	chk_mcast_drop: assert property (i_sa_valid |=> o_sa_result_valid &&
		o_sa_drop_mcast == $past(i_sa[SA_GROUP_BIT] && !mcf_ff)) else $error("mcast drop wrong");
	chk_flush_mask: assert property (o_flush_start && o_flush_kind != KIND_PORT
		|-> o_flush_port_mask == 3'h7) else $error("flush mask not all ports");
	chk_start_pulse: assert property (o_flush_start |=> !o_flush_start)
		else $error("flush start longer than a cycle");
	chk_flush_end: assert property ((o_flush_dynamic || o_flush_static) && i_flush_done
		|=> !o_flush_dynamic && !o_flush_static) else $error("flush did not end");
endmodule
bind lookup_engine_control lec_checker chk (.*);

// file: tb_top.sv
// register level testbench for the lookup engine control block
`timescale 1ns/10ps
module tb_top;
	import lookup_engine_control_pkg::*;
	logic i_clock = 1'b0, i_arst_n = 1'b0, i_wr = 1'b0, i_rd = 1'b0, i_sa_valid = 1'b0;
	logic i_lookup_valid = 1'b0, i_lookup_hit, i_lookup_static, i_lookup_reserved_mc;
	logic i_double_tag_mode, i_flush_done = 1'b0;
	logic [15:0] i_addr = 16'h0;
	logic [7:0]  i_wdata = 8'h0, o_rdata;
	logic [47:0] i_switch_mac = 48'h02A1B2C3D4E5, i_sa = 48'h0;
	logic [2:0]  i_port_self_filt_en = 3'h3, i_lookup_map, i_vlan_map, i_link_up = 3'h7;
	logic [1:0]  i_sa_port = 2'h0, o_maca_prio;
	logic        o_sa_result_valid, o_sa_drop_self, o_sa_drop_mcast, o_fwd_valid;
	logic        o_flush_start, o_flush_dynamic, o_flush_static;
	logic        o_learn_disable, o_aging_enable, o_fast_aging;
	logic [2:0]  o_fwd_map, o_flush_port_mask;
	flush_kind_t o_flush_kind;
	int mismatches = 0;
	int checks = 0;
	int starts = 0;
	lookup_engine_control uut (.*);
	always #5 i_clock = ~i_clock;
	// starts counted between edges, so a one cycle pulse is never missed
	always @(negedge i_clock) begin
		if (o_flush_start === 1'b1) begin
			starts++;
		end
	end
	task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
		checks++;
		if (seen !== exp) begin
			mismatches++;
			$display("mismatch %s expected %h seen %h", name, exp, seen);
		end
	endtask
	task automatic report_and_stop();
		$display("checks %0d mismatches %0d", checks, mismatches);
		if (mismatches == 0 && checks > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask
	task automatic wr(input logic [15:0] a, input logic [7:0] d);
		@(posedge i_clock);
		i_wr <= 1'b1;
		i_addr <= a;
		i_wdata <= d;
		@(posedge i_clock);
		i_wr <= 1'b0;
	endtask
	task automatic rd(input logic [15:0] a, input logic [7:0] e);
		@(posedge i_clock);
		i_rd <= 1'b1;
		i_addr <= a;
		@(posedge i_clock);
		i_rd <= 1'b0;
		#1 check("rdata", o_rdata, e);
	endtask
	task automatic sa(input logic [1:0] p, input logic [47:0] m, input logic [1:0] e);
		@(posedge i_clock);
		i_sa_valid <= 1'b1;
		i_sa_port <= p;
		i_sa <= m;
		@(posedge i_clock);
		i_sa_valid <= 1'b0;
		#1 check("sa_drop", {5'h0, o_sa_result_valid, o_sa_drop_self, o_sa_drop_mcast}, {6'h1, e});
	endtask
	// q holds hit, static, reserved multicast, double tag
	task automatic lk(input logic [3:0] q, input logic [2:0] lm, vm, e);
		@(posedge i_clock);
		i_lookup_valid <= 1'b1;
		{i_lookup_hit, i_lookup_static, i_lookup_reserved_mc, i_double_tag_mode} <= q;
		i_lookup_map <= lm;
		i_vlan_map <= vm;
		@(posedge i_clock);
		i_lookup_valid <= 1'b0;
		#1 check("fwd", {4'h0, o_fwd_valid, o_fwd_map}, {5'h01, e});
	endtask
	task automatic flush(input flush_kind_t k, input logic [2:0] m, input logic [1:0] ds,
			input logic [7:0] busy, idle);
		int n;
		n = 0;
		while (o_flush_start !== 1'b1 && n < 20) begin
			@(posedge i_clock);
			#1 n++;
		end
		if (n >= 20) begin
			mismatches++;
			report_and_stop();
		end else begin
			check("flush", {1'b0, o_flush_kind, o_flush_port_mask, o_flush_dynamic,
				o_flush_static}, {1'b0, k, m, ds});
			rd(ADDR_CTRL_1, busy);
			@(posedge i_clock);
			i_flush_done <= 1'b1;
			@(posedge i_clock);
			i_flush_done <= 1'b0;
			rd(ADDR_CTRL_1, idle);
		end
	endtask
	initial begin
		{i_lookup_hit, i_lookup_static, i_lookup_reserved_mc, i_double_tag_mode} = 4'h0;
		i_lookup_map = 3'h0;
		i_vlan_map = 3'h0;
		repeat (16) @(posedge i_clock);
		i_arst_n <= 1'b1;
		#1 check("aging", {7'h0, o_aging_enable}, 8'h01);
		rd(ADDR_CTRL_1, 8'h0C);
		rd(ADDR_CTRL_2, 8'h00);
		rd(16'h0313, 8'h00);
		wr(ADDR_CTRL_1, 8'hC2);
		wr(16'h0313, 8'hFF);
		rd(ADDR_CTRL_1, 8'hC2);
		check("ctl", {5'h0, o_learn_disable, o_aging_enable, o_fast_aging}, 8'h05);
		wr(ADDR_CTRL_2, 8'h83);
		rd(ADDR_CTRL_2, 8'h83);
		check("prio", {6'h0, o_maca_prio}, 8'h03);
		$display("test registers done");
		sa(2'h0, i_switch_mac, 2'h2);
		sa(2'h2, i_switch_mac, 2'h0);
		sa(2'h1, 48'h010000000001, 2'h1);
		wr(ADDR_CTRL_1, 8'h0C);
		sa(2'h0, i_switch_mac, 2'h0);
		sa(2'h1, 48'h010000000001, 2'h0);
		$display("test source checks done");
		wr(ADDR_CTRL_2, 8'h70);
		lk(4'h3, 3'h3, 3'h1, 3'h4);
		lk(4'h2, 3'h3, 3'h1, 3'h3);
		lk(4'h8, 3'h7, 3'h2, 3'h2);
		lk(4'hC, 3'h6, 3'h3, 3'h2);
		lk(4'h0, 3'h5, 3'h2, 3'h5);
		wr(ADDR_CTRL_2, 8'h20);
		lk(4'hC, 3'h6, 3'h3, 3'h6);
		lk(4'hB, 3'h7, 3'h2, 3'h2);
		wr(ADDR_CTRL_2, 8'h10);
		lk(4'h8, 3'h7, 3'h2, 3'h7);
		$display("test forwarding done");
		for (int o = 1; o < 4; o++) begin
			wr(ADDR_CTRL_2, {4'h0, o[1:0], 2'h0});
			wr(ADDR_CTRL_1, 8'h2C);
			flush(KIND_ALL, 3'h7, {o[0], o[1]}, 8'h2C, 8'h0C);
			wr(ADDR_CTRL_1, 8'h1C);
			flush(KIND_MSTP, 3'h7, {o[0], o[1]}, 8'h1C, 8'h0C);
		end
		// option zero completes at once with no walk
		wr(ADDR_CTRL_2, 8'h00);
		wr(ADDR_CTRL_1, 8'h2C);
		rd(ADDR_CTRL_1, 8'h0C);
		check("start", starts[7:0], 8'h06);
		wr(ADDR_CTRL_2, 8'h0C);
		// link drop with the flush bit clear must not start a walk
		@(posedge i_clock);
		i_link_up <= 3'h3;
		repeat (4) @(posedge i_clock);
		check("starts", starts[7:0], 8'h06);
		wr(ADDR_CTRL_1, 8'h0D);
		@(posedge i_clock);
		i_link_up <= 3'h1;
		flush(KIND_PORT, 3'h2, 2'h3, 8'h0D, 8'h0D);
		check("starts", starts[7:0], 8'h07);
		$display("test flushes done");
		report_and_stop();
	end
endmodule
